/* lcdhi_consts.vh */
// Constants of the LCD host interface: modes, limits, reset values.
// Assumes inclusion by bare name from every design file.
`ifndef LCDHI_CONSTS_VH
`define LCDHI_CONSTS_VH

// Interface select codes, {select_a, select_b}.
`define LCDHI_MODE_STROBE 2'b01
`define LCDHI_MODE_ENABLE 2'b11
`define LCDHI_MODE_SERIAL 2'b10
`define LCDHI_MODE_RESET  2'b00

// Display RAM geometry.
`define LCDHI_COL_LAST    7'h4f
`define LCDHI_COLS        9'd80
`define LCDHI_PAGE_IND    4'h4
`define LCDHI_RAM_WORDS   400
`define LCDHI_LINE_LAST   6'h20

// Status byte layout.
`define LCDHI_BUSY_BIT    7

// Reset values.
`define LCDHI_COL_RST     7'h00
`define LCDHI_PAGE_RST    4'h0
`define LCDHI_START_RST   5'h00
`define LCDHI_LINE_RST    6'h00

`endif

/* lcdhi_serial_rx.v */
// Serial byte receiver: shift register and bit counter.
// Assumes the serial clock edge is already synchronised to core_clk_in.
`default_nettype none
`include "lcdhi_consts.vh"

module lcdhi_serial_rx (
  // Clock and reset.
  input  wire       core_clk_in,
  input  wire       rstn_in,
  // Link side, already synchronised.
  input  wire       enable_in,
  input  wire       sclk_rise_in,
  input  wire       sdata_in,
  input  wire       dc_in,
  // Received byte.
  output reg        byte_valid_out,
  output reg  [7:0] byte_out,
  output reg        byte_dc_out
);

  reg [7:0] shift_q;
  reg [2:0] count_q;

  // Shift in MSB first; deliver on every eighth edge.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_q        <= 8'h00;
      count_q        <= 3'h0;
      byte_valid_out <= 1'b0;
      byte_out       <= 8'h00;
      byte_dc_out    <= 1'b0;
    end else begin
      byte_valid_out <= 1'b0;
      if (!enable_in) begin
        shift_q <= 8'h00;
        count_q <= 3'h0;
      end else if (sclk_rise_in) begin
        shift_q <= {shift_q[6:0], sdata_in};
        count_q <= count_q + 3'h1;
        if (count_q == 3'h7) begin
          byte_valid_out <= 1'b1;
          byte_out       <= {shift_q[6:0], sdata_in};
          byte_dc_out    <= dc_in;
        end
      end
    end
  end

endmodule // lcdhi_serial_rx
`default_nettype wire

/* lcdhi_fifo2.v */
// Small valid/ready buffer, two entries by default.
// Assumes both sides run on core_clk_in.
`default_nettype none
`include "lcdhi_consts.vh"

module lcdhi_fifo2 #(
  parameter WIDTH = 8,
  parameter AW    = 1
) (
  // Clock and reset.
  input  wire             core_clk_in,
  input  wire             rstn_in,
  // Filling side.
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Draining side.
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  reg [WIDTH-1:0] mem_q [0:(1<<AW)-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Honest full and empty flags.
  assign in_ready_out  = (count_q != DEPTH);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // Storage is written without reset.
  always @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointers and fill count.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end

endmodule // lcdhi_fifo2
`default_nettype wire

/* lcdhi_top.v */
// LCD driver host interface: bus decode, bus holder, busy flag,
// column, page, start line and line counter, display RAM.
// Assumes all pins are asynchronous to core_clk_in and that an
// outside command executor drains the command buffer and loads
// the address registers through the load ports.
//
// Overview of operation
// - Select pins pick strobe, enable, serial bus, or hold reset.
// - Serial mode never drives the bus: no data or status reads.
// - Data/command select and read/write decode data, status, command.
// - Serial receiver is 8-bit shifter plus 3-bit counter, selected only.
// - Deselection clears the shifter and counter.
// - Serial data sampled on rising serial clock, MSB first.
// - Every eighth rising edge delivers one whole byte.
// - Data/command select sampled at eighth edge: high data, low command.
// - Only low-active select low and high-active select high respond.
// - Reset works regardless of select; deselection clears only the serial shifter and counter.
// - Data reads go through the holder; first read after change is dummy.
// - Written data waits in holder, committed to RAM before next write.
// - Busy flag refuses all but status reads; it shows on bit seven.
// - Start-line load sets the five-bit first displayed line.
// - Line counter preloads from start line on frame alternation change.
// - Line counter steps on oscillator or line clock, addresses RAM rows.
// - Seven-bit column counter steps after each data read or write.
// - Column past the last one locks the counter until reloaded.
// - Column reverse swaps RAM column to segment mapping.
// - Four-bit page register selects the page for host access.
// - Page four is indicator: only bit zero is stored.
// - Host writes may happen while scan reads RAM.
`default_nettype none
`include "lcdhi_consts.vh"

module lcdhi_top (
  // Clock and reset.
  input  wire       core_clk_in,
  input  wire       rstn_in,
  // Interface select straps.
  input  wire       interface_select_a_in,
  input  wire       interface_select_b_in,
  // Host bus pins.
  input  wire       chip_select_low_active_n_in,
  input  wire       chip_select_high_active_in,
  input  wire       data_command_select_in,
  input  wire       rd_e_in,
  input  wire       wr_rw_in,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_out,
  // Display scan side.
  input  wire       master_mode_in,
  input  wire       osc_clk_in,
  input  wire       line_clock_in,
  input  wire       frame_alternation_in,
  input  wire [6:0] scan_col_in,
  output wire [5:0] line_addr_out,
  output reg        scan_bit_out,
  // Command buffer toward the executor.
  output wire       cmd_valid_out,
  input  wire       cmd_ready_in,
  output wire [7:0] cmd_data_out,
  // Register loads from the executor.
  input  wire       start_line_load_in,
  input  wire [4:0] start_line_in,
  input  wire       page_load_in,
  input  wire [3:0] page_in,
  input  wire       column_load_in,
  input  wire [6:0] column_in,
  input  wire       column_reverse_in,
  // Status.
  output wire       busy_out
);

  ////////////////////////////////////////////////////////////////////
  // Declarations.

  reg  [18:0] sync1_q;
  reg  [18:0] sync2_q;
  reg         acc_prev_q;
  reg         sclk_prev_q;
  reg         osc_prev_q;
  reg         lclk_prev_q;
  reg         frame_prev_q;
  reg         acc_rd_q;
  reg         acc_dc_q;
  reg  [7:0]  holder_q;
  reg         commit_q;
  reg  [6:0]  col_q;
  reg  [3:0]  page_q;
  reg  [4:0]  start_q;
  reg  [5:0]  line_q;
  reg  [7:0]  ram_q [0:`LCDHI_RAM_WORDS-1];
  reg  [7:0]  host_rd_data;
  reg  [7:0]  wr_byte;
  reg         wr_data_ev;
  reg         wr_cmd_ev;
  reg         rd_data_ev;
  wire [18:0] pins;
  wire        cs_n_s;
  wire        cs_s;
  wire        dc_s;
  wire        rd_s;
  wire        wr_s;
  wire [7:0]  data_s;
  wire [1:0]  mode_s;
  wire        master_s;
  wire        osc_s;
  wire        lclk_s;
  wire        frame_s;
  wire        selected;
  wire        soft_rst;
  wire        par_mode;
  wire        acc_now;
  wire        acc_active;
  wire        acc_start;
  wire        acc_finish;
  wire        is_read_now;
  wire        sclk_rise;
  wire        step_tick;
  wire        ser_valid;
  wire [7:0]  ser_byte;
  wire        ser_dc;
  wire        cmd_in_ready;
  wire        col_open;
  wire [6:0]  scan_col_map;
  wire [3:0]  scan_page;

  ////////////////////////////////////////////////////////////////////
  // Helper functions.

  // RAM word index of a page and column.
  function [8:0] ram_index;
    input [3:0] page;
    input [6:0] col;
    begin
      ram_index = page * `LCDHI_COLS + {2'b00, col};
    end
  endfunction

  // True when page and column exist in the RAM.
  function in_range;
    input [3:0] page;
    input [6:0] col;
    begin
      in_range = (page <= `LCDHI_PAGE_IND) && (col <= `LCDHI_COL_LAST);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  assign pins = {interface_select_a_in, interface_select_b_in,
                 chip_select_low_active_n_in,
                 chip_select_high_active_in, data_command_select_in,
                 rd_e_in, wr_rw_in, data_in, master_mode_in,
                 osc_clk_in, line_clock_in, frame_alternation_in};

  // Two flip-flops on every pin before any logic looks at it.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 19'h0_0000;
      sync2_q <= 19'h0_0000;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  assign mode_s   = sync2_q[18:17];
  assign cs_n_s   = sync2_q[16];
  assign cs_s     = sync2_q[15];
  assign dc_s     = sync2_q[14];
  assign rd_s     = sync2_q[13];
  assign wr_s     = sync2_q[12];
  assign data_s   = sync2_q[11:4];
  assign master_s = sync2_q[3];
  assign osc_s    = sync2_q[2];
  assign lclk_s   = sync2_q[1];
  assign frame_s  = sync2_q[0];

  ////////////////////////////////////////////////////////////////////
  // Mode and access decode.

  assign selected = !cs_n_s && cs_s;
  assign soft_rst = (mode_s == `LCDHI_MODE_RESET);
  assign par_mode = (mode_s == `LCDHI_MODE_STROBE) ||
                    (mode_s == `LCDHI_MODE_ENABLE);
  // Strobe style: active-low strobes; enable style: E high, R/W.
  assign acc_now = (mode_s == `LCDHI_MODE_STROBE) ?
                   (!rd_s || !wr_s) : rd_s;
  assign is_read_now = (mode_s == `LCDHI_MODE_STROBE) ?
                       !rd_s : wr_s;
  assign acc_active = par_mode && selected && acc_now;
  assign acc_start  = acc_active && !acc_prev_q;
  assign acc_finish = !acc_active && acc_prev_q;
  assign sclk_rise  = data_s[6] && !sclk_prev_q;
  assign busy_out   = commit_q || !cmd_in_ready;
  assign col_open   = (col_q <= `LCDHI_COL_LAST);

  // Edge history registers.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_prev_q   <= 1'b0;
      sclk_prev_q  <= 1'b0;
      osc_prev_q   <= 1'b0;
      lclk_prev_q  <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      acc_prev_q   <= acc_active;
      sclk_prev_q  <= data_s[6];
      osc_prev_q   <= osc_s;
      lclk_prev_q  <= lclk_s;
      frame_prev_q <= frame_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial receiver and command buffer.

  lcdhi_serial_rx u_serial (
    .core_clk_in    (core_clk_in),
    .rstn_in        (rstn_in),
    .enable_in      (mode_s == `LCDHI_MODE_SERIAL && selected),
    .sclk_rise_in   (sclk_rise),
    .sdata_in       (data_s[7]),
    .dc_in          (dc_s),
    .byte_valid_out (ser_valid),
    .byte_out       (ser_byte),
    .byte_dc_out    (ser_dc)
  );

  lcdhi_fifo2 #(
    .WIDTH (8),
    .AW    (1)
  ) u_cmd_buf (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (wr_cmd_ev),
    .in_ready_out  (cmd_in_ready),
    .in_data_in    (wr_byte),
    .out_valid_out (cmd_valid_out),
    .out_ready_in  (cmd_ready_in),
    .out_data_out  (cmd_data_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Operation events from either front end.

  // Busy refuses every operation except status reads.
  always @* begin
    wr_byte    = data_s;
    wr_data_ev = 1'b0;
    wr_cmd_ev  = 1'b0;
    rd_data_ev = 1'b0;
    if (ser_valid && !soft_rst && !busy_out) begin
      wr_byte    = ser_byte;
      wr_data_ev = ser_dc;
      wr_cmd_ev  = !ser_dc;
    end else if (acc_finish && !busy_out) begin
      wr_data_ev = !acc_rd_q && acc_dc_q;
      wr_cmd_ev  = !acc_rd_q && !acc_dc_q;
      rd_data_ev = acc_rd_q && acc_dc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus output and holder.

  // Host read port; absent cells read as zero.
  always @* begin
    host_rd_data = 8'h00;
    if (in_range(page_q, col_q)) begin
      host_rd_data = ram_q[ram_index(page_q, col_q)];
    end
  end

  // Drive holder or status while a read access is open.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
      acc_rd_q    <= 1'b0;
      acc_dc_q    <= 1'b0;
    end else if (acc_start) begin
      acc_rd_q    <= is_read_now;
      acc_dc_q    <= dc_s;
      data_oe_out <= is_read_now;
      data_out    <= 8'h00;
      if (dc_s) begin
        data_out <= holder_q;
      end else begin
        data_out[`LCDHI_BUSY_BIT] <= busy_out;
      end
    end else if (!acc_active) begin
      data_oe_out <= 1'b0;
    end
  end

  // Holder and commit: reads prefetch, writes wait one cycle.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      holder_q <= 8'h00;
      commit_q <= 1'b0;
    end else if (soft_rst) begin
      holder_q <= 8'h00;
      commit_q <= 1'b0;
    end else begin
      commit_q <= wr_data_ev;
      if (wr_data_ev) begin
        holder_q <= wr_byte;
      end else if (rd_data_ev) begin
        holder_q <= host_rd_data;
      end
    end
  end

  // RAM write from the holder; the scan port is separate.
  always @(posedge core_clk_in) begin
    if (commit_q && in_range(page_q, col_q)) begin
      if (page_q == `LCDHI_PAGE_IND) begin
        ram_q[ram_index(page_q, col_q)] <=
          {7'h00, holder_q[0]};
      end else begin
        ram_q[ram_index(page_q, col_q)] <= holder_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address registers.

  // Column counter, page and start line; loads and select-code reset act regardless of select.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      col_q   <= `LCDHI_COL_RST;
      page_q  <= `LCDHI_PAGE_RST;
      start_q <= `LCDHI_START_RST;
    end else if (soft_rst) begin
      col_q   <= `LCDHI_COL_RST;
      page_q  <= `LCDHI_PAGE_RST;
      start_q <= `LCDHI_START_RST;
    end else begin
      if (column_load_in) begin
        col_q <= column_in;
      end else if ((commit_q || rd_data_ev) && col_open) begin
        col_q <= col_q + 7'h01;
      end
      if (page_load_in) begin
        page_q <= page_in;
      end
      if (start_line_load_in) begin
        start_q <= start_line_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Line counter and scan read port.

  assign step_tick = master_s ? (osc_s && !osc_prev_q) :
                                (lclk_s && !lclk_prev_q);
  assign line_addr_out = line_q;

  // Preload on frame change, otherwise step and wrap.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_q <= `LCDHI_LINE_RST;
    end else if (soft_rst) begin
      line_q <= `LCDHI_LINE_RST;
    end else if (frame_s != frame_prev_q) begin
      line_q <= {1'b0, start_q};
    end else if (step_tick) begin
      if (line_q >= `LCDHI_LINE_LAST) begin
        line_q <= `LCDHI_LINE_RST;
      end else begin
        line_q <= line_q + 6'h01;
      end
    end
  end

  assign scan_col_map = column_reverse_in ?
                        (`LCDHI_COL_LAST - scan_col_in) :
                        scan_col_in;
  assign scan_page = {1'b0, line_q[5:3]};

  // Scan port reads in parallel with host writes.
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scan_bit_out <= 1'b0;
    end else if (in_range(scan_page, scan_col_map)) begin
      scan_bit_out <= ram_q[ram_index(scan_page, scan_col_map)]
                      [line_q[2:0]];
    end else begin
      scan_bit_out <= 1'b0;
    end
  end

endmodule // lcdhi_top
`default_nettype wire

/* lcdhi_props.sv */
// Checker of the host pins of lcdhi_top.
// Assumes binding to the top module and pins held long past sync.
`default_nettype none
module lcdhi_props (
  // Clock and reset.
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  // Host pins.
  input wire logic       interface_select_a_in,
  input wire logic       interface_select_b_in,
  input wire logic       chip_select_low_active_n_in,
  input wire logic       chip_select_high_active_in,
  input wire logic       data_command_select_in,
  input wire logic       rd_e_in,
  input wire logic       wr_rw_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_out,
  // Scan and command side.
  input wire logic [5:0] line_addr_out,
  input wire logic       cmd_valid_out,
  input wire logic       cmd_ready_in,
  input wire logic [7:0] cmd_data_out,
  input wire logic       busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Selected read in either parallel mode, and the two special modes.
  wire sel_w = !chip_select_low_active_n_in && chip_select_high_active_in;
  wire rd_w  = sel_w && interface_select_b_in && (interface_select_a_in ?
               rd_e_in && wr_rw_in : !rd_e_in);
  wire ser_w = interface_select_a_in && !interface_select_b_in;
  wire off_w = !interface_select_a_in && !interface_select_b_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_read_held;
    rd_w [*6];
  endsequence
  sequence s_no_read;
    !rd_w [*5];
  endsequence
  a_reset_quiet:
    assert property (disable iff (1'b0)
      !rstn_in |-> !data_oe_out && !cmd_valid_out && !busy_out)
    else $error("outputs active in reset");
  a_serial_silent:
    assert property (ser_w [*6] |-> !data_oe_out)
    else $error("bus driven in serial mode");
  a_read_drives:
    assert property (s_read_held |-> data_oe_out)
    else $error("read not answered");
  a_oe_cause:
    assert property ($rose(data_oe_out) |-> $past(rd_w, 2))
    else $error("bus driven without selected read");
  a_oe_release:
    assert property (s_no_read |-> !data_oe_out)
    else $error("bus held after read");
  a_status_byte:
    assert property ((rd_w && !data_command_select_in) [*6]
      |-> data_out[6:0] == 7'h00)
    else $error("status low bits not zero");
  a_cmd_hold:
    assert property (cmd_valid_out && !cmd_ready_in
      |=> cmd_valid_out && $stable(cmd_data_out))
    else $error("command lost while stalled");
  a_line_range:
    assert property (line_addr_out <= 6'h20)
    else $error("line address out of range");
  a_soft_reset:
    assert property (off_w [*6] |-> line_addr_out == 6'h00 && !data_oe_out)
    else $error("select code zero not resetting");
endmodule // lcdhi_props
bind lcdhi_top lcdhi_props u_props (
  .core_clk_in, .rstn_in, .interface_select_a_in, .interface_select_b_in,
  .chip_select_low_active_n_in, .chip_select_high_active_in,
  .data_command_select_in, .rd_e_in, .wr_rw_in, .data_out, .data_oe_out,
  .line_addr_out, .cmd_valid_out, .cmd_ready_in, .cmd_data_out, .busy_out
);
`default_nettype wire

/* lcdhi_host.sv */
// Host processor model on the parallel and serial pins.
// Assumes a 100 MHz core clock; pins move at its falling edge.
`default_nettype none
module lcdhi_host (
  // Clock.
  input wire logic       core_clk_in,
  // Pins toward the device.
  output var logic       sel_a_out,
  output var logic       sel_b_out,
  output var logic       cs_n_out,
  output var logic       cs_out,
  output var logic       dc_out,
  output var logic       rd_e_out,
  output var logic       wr_rw_out,
  output wire logic [7:0] bus_out,
  // Device side of the bus.
  input wire logic [7:0] dev_data_in,
  input wire logic       dev_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hd;
  logic       csok;
  // Device wins while driving; a released host shows the inverse.
  assign bus_out = dev_oe_in ? dev_data_in : hd;
  // Idle pin levels.
  initial begin
    {sel_a_out, sel_b_out, cs_out, dc_out, hd} = '0;
    {cs_n_out, rd_e_out, wr_rw_out, csok} = '1;
  end
  // Raises select A with or before B, lowers later.
  task automatic mode(input logic a, input logic b);
    @(negedge core_clk_in);
    sel_a_out = sel_a_out | a;
    sel_b_out = sel_b_out | b;
    repeat (2) @(negedge core_clk_in);
    sel_a_out = a;
    sel_b_out = b;
    rd_e_out = !a;
    repeat (8) @(negedge core_clk_in);
  endtask
  // One parallel access, strobe held well past the synchronisers.
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] w,
                      output logic [7:0] r);
    @(negedge core_clk_in);
    cs_n_out = !csok;
    cs_out = csok;
    dc_out = dc;
    hd = rd ? ~hd : w;
    if (sel_a_out) wr_rw_out = rd;
    @(negedge core_clk_in);
    if (sel_a_out) rd_e_out = 1'b1;
    else if (rd) rd_e_out = 1'b0;
    else wr_rw_out = 1'b0;
    repeat (6) @(negedge core_clk_in);
    r = bus_out;
    rd_e_out = !sel_a_out;
    if (!sel_a_out) wr_rw_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
    {cs_n_out, cs_out, wr_rw_out} = 3'b101;
    hd = ~hd;
    repeat (2) @(negedge core_clk_in);
  endtask
  // Shifts n bits MSB first on D7, clock on D6 rising.
  task automatic sbyte(input logic dc, input logic [7:0] b, input int n);
    @(negedge core_clk_in);
    {cs_n_out, cs_out, dc_out} = {2'b01, dc};
    for (int i = 7; i > 7 - n; i--) begin
      hd = {b[i], 1'b0, ~hd[5:0]};
      repeat (4) @(negedge core_clk_in);
      hd[6] = 1'b1;
      repeat (4) @(negedge core_clk_in);
    end
    hd[7:6] = {~hd[7], 1'b0};
    repeat (4) @(negedge core_clk_in);
    {cs_n_out, cs_out} = 2'b10;
    repeat (4) @(negedge core_clk_in);
  endtask
endmodule // lcdhi_host
`default_nettype wire

/* lcdhi_top_tb.sv */
// Self-checking bench of lcdhi_top driven through the host model.
// Assumes the checker is bound from its own file.
`default_nettype none
module lcdhi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rstn, master, osc, lclk, fa, crev, cr, sll, pl, cl;
  logic       sa, sb, csn, cs, dc, rde, wrw, oe, sbit, cv, busy;
  logic [7:0] din, dout, cd, r;
  logic [6:0] scol, col;
  logic [5:0] line;
  logic [4:0] sl;
  logic [3:0] pg;
  int         miscompares = 0;
  int         samples_checked = 0;
  lcdhi_top DUT (
    .core_clk_in(clk), .rstn_in(rstn), .interface_select_a_in(sa),
    .interface_select_b_in(sb), .chip_select_low_active_n_in(csn),
    .chip_select_high_active_in(cs), .data_command_select_in(dc),
    .rd_e_in(rde), .wr_rw_in(wrw), .data_in(din), .data_out(dout),
    .data_oe_out(oe), .master_mode_in(master), .osc_clk_in(osc),
    .line_clock_in(lclk), .frame_alternation_in(fa), .scan_col_in(scol),
    .line_addr_out(line), .scan_bit_out(sbit), .cmd_valid_out(cv),
    .cmd_ready_in(cr), .cmd_data_out(cd), .start_line_load_in(sll),
    .start_line_in(sl), .page_load_in(pl), .page_in(pg),
    .column_load_in(cl), .column_in(col), .column_reverse_in(crev),
    .busy_out(busy));
  lcdhi_host host (
    .core_clk_in(clk), .sel_a_out(sa), .sel_b_out(sb), .cs_n_out(csn),
    .cs_out(cs), .dc_out(dc), .rd_e_out(rde), .wr_rw_out(wrw),
    .bus_out(din), .dev_data_in(dout), .dev_oe_in(oe));
  // Free-running 100 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compares one seen value with its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Pulses one executor load: 0 column, 1 page, 2 start line.
  task automatic ld(input int k, input logic [6:0] v);
    @(negedge clk);
    {col, pg, sl} = {v, v[3:0], v[4:0]};
    {cl, pl, sll} = {k == 0, k == 1, k == 2};
    @(negedge clk);
    {cl, pl, sll} = 3'b000;
    repeat (2) @(negedge clk);
  endtask
  // Writes one display byte at a page and column.
  task automatic poke(input logic [3:0] p, input logic [6:0] c,
                      input logic [7:0] w);
    ld(1, 7'(p));
    ld(0, c);
    host.xfer(1'b0, 1'b1, w, r);
  endtask
  // Sets the address, spends the dummy read, checks the real one.
  task automatic peek(input logic [3:0] p, input logic [6:0] c,
                      input logic [7:0] e);
    ld(1, 7'(p));
    ld(0, c);
    host.xfer(1'b1, 1'b1, 8'h00, r);
    host.xfer(1'b1, 1'b1, 8'h00, r);
    chk(16'(r), 16'(e));
  endtask
  // Lets the executor take one command, then shows the buffer head.
  task automatic pop;
    @(negedge clk);
    cr = 1'b1;
    @(negedge clk);
    cr = 1'b0;
    @(negedge clk);
  endtask
  // Pulses a scan clock input high and low.
  task automatic tick(ref logic s);
    s = 1'b1;
    repeat (6) @(negedge clk);
    s = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // Main sequence of accesses and checks.
  initial begin
    {rstn, master, osc, lclk, fa, crev, cr, sll, pl, cl} = '0;
    {scol, col, sl, pg} = '0;
    repeat (16) @(negedge clk);
    chk(16'({busy, cv, oe, line}), 16'h0000);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    host.mode(1'b0, 1'b1);
    poke(4'h0, 7'h00, 8'ha5);
    host.xfer(1'b0, 1'b1, 8'h3c, r);
    ld(0, 7'h00);
    host.xfer(1'b1, 1'b1, 8'h00, r);
    host.xfer(1'b1, 1'b1, 8'h00, r);
    chk(16'(r), 16'h00a5);
    host.xfer(1'b1, 1'b1, 8'h00, r);
    chk(16'(r), 16'h003c);
    host.xfer(1'b1, 1'b0, 8'h00, r);
    chk(16'(r), 16'h0000);
    host.csok = 1'b0;
    host.xfer(1'b0, 1'b1, 8'hff, r);
    host.csok = 1'b1;
    host.xfer(1'b0, 1'b1, 8'h77, r);
    peek(4'h0, 7'h03, 8'h77);
    poke(4'h0, 7'h4f, 8'h11);
    host.xfer(1'b0, 1'b1, 8'h22, r);
    peek(4'h0, 7'h4f, 8'h11);
    poke(4'h4, 7'h00, 8'hff);
    peek(4'h4, 7'h00, 8'h01);
    peek(4'h0, 7'h00, 8'ha5);
    host.xfer(1'b0, 1'b0, 8'h81, r);
    host.xfer(1'b0, 1'b0, 8'h82, r);
    chk(16'({cv, busy, cd}), 16'h0381);
    host.xfer(1'b1, 1'b0, 8'h00, r);
    chk(16'(r), 16'h0080);
    host.xfer(1'b0, 1'b0, 8'h83, r);
    pop();
    chk(16'({cv, cd}), 16'h0182);
    pop();
    chk(16'(cv), 16'h0000);
    host.mode(1'b1, 1'b1);
    poke(4'h0, 7'h05, 8'h5a);
    peek(4'h0, 7'h05, 8'h5a);
    host.mode(1'b1, 1'b0);
    ld(0, 7'h06);
    host.sbyte(1'b1, 8'hc3, 5);
    host.sbyte(1'b1, 8'h96, 8);
    host.sbyte(1'b0, 8'h44, 8);
    chk(16'({cv, cd}), 16'h0144);
    pop();
    host.mode(1'b0, 1'b1);
    peek(4'h0, 7'h06, 8'h96);
    ld(2, 7'h05);
    fa = 1'b1;
    repeat (6) @(negedge clk);
    chk(16'(line), 16'h0005);
    master = 1'b1;
    tick(osc);
    chk(16'(line), 16'h0006);
    master = 1'b0;
    tick(lclk);
    chk(16'(line), 16'h0007);
    repeat (4) @(negedge clk);
    chk(16'(sbit), 16'h0001);
    scol = 7'h03;
    repeat (4) @(negedge clk);
    chk(16'(sbit), 16'h0000);
    crev = 1'b1;
    scol = 7'h4f;
    repeat (4) @(negedge clk);
    chk(16'(sbit), 16'h0001);
    host.mode(1'b0, 1'b0);
    chk(16'(line), 16'h0000);
    give_verdict();
  end
  // Cuts a hung run short far beyond the expected length.
  initial begin
    #300us;
    miscompares++;
    give_verdict();
  end
endmodule // lcdhi_top_tb
`default_nettype wire
